// *** hdl/gpegr_pkg.sv ***
/*
 Constants for the general-purpose event, input/output and routing registers.
 Assumes a byte-addressed configuration port carrying aligned 32-bit words.
*/
package gpegr_pkg;
    // ------------------------------------------------------------
    // Register offsets and word indexes
    // ------------------------------------------------------------
    localparam logic [7:0]  OFS_STATUS    = 8'h88;
    localparam logic [7:0]  OFS_ENABLE    = 8'h89;
    localparam logic [7:0]  OFS_INPUT     = 8'h8A;
    localparam logic [7:0]  OFS_OUTPUT    = 8'h8B;
    localparam logic [7:0]  OFS_ROUTING   = 8'h8C;
    localparam logic [5:0]  DW_EVENT      = OFS_STATUS[7:2];
    localparam logic [5:0]  DW_ROUTING    = OFS_ROUTING[7:2];
    localparam int          LANE_STATUS   = 0;
    localparam int          LANE_ENABLE   = 1;
    localparam int          LANE_INPUT    = 2;
    localparam int          LANE_OUTPUT   = 3;
    // ------------------------------------------------------------
    // Field layouts and reset values
    // ------------------------------------------------------------
    localparam int          NUM_GPIO      = 5;
    localparam int          BIT_POWER     = 7;
    localparam int          BIT_VPP       = 6;
    localparam int          BIT_RSVD      = 5;
    localparam int          BIT_IN4       = 4;
    localparam int          BIT_IN3       = 3;
    localparam logic [7:0]  EVENT_MASK    = 8'hDF;
    localparam logic [7:0]  GPIO_MASK     = 8'h1F;
    localparam logic [7:0]  BYTE_RESET    = 8'h00;
    localparam logic [31:0] ROUTING_MASK  = 32'h0FFFFFFF;
    localparam logic [31:0] ROUTING_RESET = 32'h00001000;
endpackage : gpegr_pkg

// *** hdl/gpegr_top.sv ***
/*
 General-purpose event status/enable, input level, output drive and
 multipurpose terminal routing registers with event output generation.
 Assumes a configuration port on CLK, one-cycle event pulses from the
 socket power logic, asynchronous input terminals and a serial ROM loader
 that presents a routing word with a one-cycle load strobe.
*/
`timescale 1ns/1ns
module gpegr_top
(
    // Clock and global reset
    input  wire logic        CLK,
    input  wire logic        RST_N,
    // Configuration port
    input  wire logic [7:0]  CFG_ADDR,
    input  wire logic [3:0]  CFG_BE,
    input  wire logic        CFG_WR,
    input  wire logic        CFG_RD,
    input  wire logic [31:0] CFG_WDATA,
    output logic      [31:0] CFG_RDATA,
    // Event sources from the socket power logic
    input  wire logic        POWER_CHANGE_EVENT,
    input  wire logic        HIGH_VPP_EVENT,
    // Serial ROM routing load
    input  wire logic        ROM_LOAD,
    input  wire logic [31:0] ROM_ROUTING,
    // Board terminals
    input  wire logic [4:0]  INPUT_TERMINAL,
    output logic      [4:0]  OUTPUT_TERMINAL,
    output logic             GENERAL_EVENT_OUTPUT_N,
    output logic      [27:0] MULTIPURPOSE_ROUTING
);
    import gpegr_pkg::*;

    // ------------------------------------------------------------
    // Byte lane merge
    // ------------------------------------------------------------
    function automatic logic [7:0] lane_merge(input logic [7:0] old,
                                              input logic [7:0] wr,
                                              input logic [7:0] mask,
                                              input logic       en);
        lane_merge = en ? ((old & ~mask) | (wr & mask)) : old;
    endfunction : lane_merge

    logic        hit_event;
    logic        hit_routing;
    assign hit_event   = CFG_ADDR[7:2] == DW_EVENT;
    assign hit_routing = CFG_ADDR[7:2] == DW_ROUTING;

    // ------------------------------------------------------------
    // Input synchroniser and change detect
    // ------------------------------------------------------------
    logic [4:0]  sync_a;
    logic [4:0]  input_level;
    logic [4:0]  input_prev;
    // Terminals are asynchronous: two flops before any logic reads them
    always_ff @(posedge CLK) begin
        sync_a      <= INPUT_TERMINAL;
        input_level <= sync_a;
        input_prev  <= input_level;
    end

    // ------------------------------------------------------------
    // Event status flags
    // ------------------------------------------------------------
    logic [7:0]  status;
    logic [7:0]  next_status;
    logic [7:0]  event_set;
    logic [7:0]  status_clear;
    always_comb begin
        event_set            = BYTE_RESET;
        event_set[BIT_POWER] = POWER_CHANGE_EVENT;
        event_set[BIT_VPP]   = HIGH_VPP_EVENT;
        // Inputs 4 and 3 flag a change, inputs 2..0 flag a low level
        event_set[BIT_IN4]   = input_level[BIT_IN4] ^ input_prev[BIT_IN4];
        event_set[BIT_IN3]   = input_level[BIT_IN3] ^ input_prev[BIT_IN3];
        event_set[2:0]       = ~input_level[2:0];
        status_clear         = (CFG_WR && hit_event && CFG_BE[LANE_STATUS]) ?
                               CFG_WDATA[7:0] : BYTE_RESET;
        // A new event wins over a clear in the same cycle
        next_status = ((status & ~status_clear) | event_set) & EVENT_MASK;
    end
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            status <= BYTE_RESET;
        end else begin
            status <= next_status;
        end
    end

    // ------------------------------------------------------------
    // Enable, output drive and routing registers
    // ------------------------------------------------------------
    logic [7:0]  enable;
    logic [7:0]  out_drive;
    logic [31:0] routing;
    logic [7:0]  next_enable;
    logic [7:0]  next_out_drive;
    logic [31:0] next_routing;
    always_comb begin
        next_enable    = lane_merge(enable, CFG_WDATA[15:8], EVENT_MASK,
                                    CFG_WR && hit_event && CFG_BE[LANE_ENABLE]);
        next_out_drive = lane_merge(out_drive, CFG_WDATA[31:24], GPIO_MASK,
                                    CFG_WR && hit_event && CFG_BE[LANE_OUTPUT]);
        next_routing   = routing;
        for (int i = 0; i < 4; i++) begin
            next_routing[8*i +: 8] = lane_merge(routing[8*i +: 8], CFG_WDATA[8*i +: 8],
                                                ROUTING_MASK[8*i +: 8],
                                                CFG_WR && hit_routing && CFG_BE[i]);
        end
        // A serial ROM load wins over a same-cycle configuration write
        if (ROM_LOAD) begin
            next_routing = ROM_ROUTING & ROUTING_MASK;
        end
    end
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            enable    <= BYTE_RESET;
            out_drive <= BYTE_RESET;
            routing   <= ROUTING_RESET;
        end else begin
            enable    <= next_enable;
            out_drive <= next_out_drive;
            routing   <= next_routing;
        end
    end

    // ------------------------------------------------------------
    // Outputs and read data
    // ------------------------------------------------------------
    logic [31:0] next_rdata;
    logic        next_event_n;
    always_comb begin
        next_rdata = 32'h00000000;
        if (CFG_RD && hit_event) begin
            next_rdata = {out_drive & GPIO_MASK, {3'h0, input_level},
                          enable & EVENT_MASK, status};
        end else if (CFG_RD && hit_routing) begin
            next_rdata = routing & ROUTING_MASK;
        end
        next_event_n = ~|(status & enable);
    end
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            CFG_RDATA              <= 32'h00000000;
            OUTPUT_TERMINAL        <= 5'h00;
            GENERAL_EVENT_OUTPUT_N <= 1'h1;
            MULTIPURPOSE_ROUTING   <= ROUTING_RESET[27:0];
        end else begin
            CFG_RDATA              <= next_rdata;
            OUTPUT_TERMINAL        <= out_drive[4:0];
            GENERAL_EVENT_OUTPUT_N <= next_event_n;
            MULTIPURPOSE_ROUTING   <= routing[27:0];
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_out_write;
        CFG_WR && hit_event && CFG_BE[LANE_OUTPUT];
    endsequence
    sequence s_event_read;
        CFG_RD && hit_event;
    endsequence

    a_power_event: assert property (@(posedge CLK) disable iff (!RST_N)
        status[BIT_POWER] && enable[BIT_POWER] |=> !GENERAL_EVENT_OUTPUT_N)
        else $error("power event not signalled");
    a_vpp_event: assert property (@(posedge CLK) disable iff (!RST_N)
        status[BIT_VPP] && enable[BIT_VPP] |=> !GENERAL_EVENT_OUTPUT_N)
        else $error("high vpp event not signalled");
    a_input_event: assert property (@(posedge CLK) disable iff (!RST_N)
        |(status[4:0] & enable[4:0]) |=> !GENERAL_EVENT_OUTPUT_N)
        else $error("input event not signalled");
    a_event_gated: assert property (@(posedge CLK) disable iff (!RST_N)
        !(|(status & enable)) |=> GENERAL_EVENT_OUTPUT_N)
        else $error("event output without enabled flag");
    a_enable_rsvd: assert property (@(posedge CLK) disable iff (!RST_N)
        s_event_read |=> CFG_RDATA[8 + BIT_RSVD] == 1'b0)
        else $error("reserved enable bit reads one");
    a_global_reset: assert property (@(posedge CLK)
        !RST_N |=> enable == BYTE_RESET && out_drive == BYTE_RESET
                   && routing == ROUTING_RESET)
        else $error("reset did not clear registers");
    a_input_track: assert property (@(posedge CLK) disable iff (!RST_N)
        s_event_read ##1 1'b1 |-> CFG_RDATA[20:16] == $past(INPUT_TERMINAL, 3))
        else $error("input level does not follow terminal");
    a_io_rsvd: assert property (@(posedge CLK) disable iff (!RST_N)
        s_event_read |=> CFG_RDATA[23:21] == 3'h0 && CFG_RDATA[31:29] == 3'h0)
        else $error("reserved io bits read nonzero");
    a_output_drive: assert property (@(posedge CLK) disable iff (!RST_N)
        s_out_write |=> ##1 OUTPUT_TERMINAL == $past(CFG_WDATA[28:24], 2))
        else $error("output terminal not driven from write");
    a_rom_load: assert property (@(posedge CLK) disable iff (!RST_N)
        ROM_LOAD |=> routing == ($past(ROM_ROUTING) & ROUTING_MASK))
        else $error("routing not loaded from rom");
    a_route_rsvd: assert property (@(posedge CLK) disable iff (!RST_N)
        CFG_RD && hit_routing |=> CFG_RDATA[31:28] == 4'h0)
        else $error("routing reserved bits nonzero");
    a_flag_set_wins: assert property (@(posedge CLK) disable iff (!RST_N)
        POWER_CHANGE_EVENT |=> status[BIT_POWER])
        else $error("power change flag lost");
    a_flag_holds: assert property (@(posedge CLK) disable iff (!RST_N)
        status[BIT_POWER] && !(CFG_WR && hit_event && CFG_BE[LANE_STATUS])
        |=> status[BIT_POWER])
        else $error("power flag cleared without write");

    // ------------------------------------------------------------
    // Assertions: register writes and retention
    // ------------------------------------------------------------
    sequence s_status_write;
        CFG_WR && hit_event && CFG_BE[LANE_STATUS];
    endsequence
    sequence s_enable_write;
        CFG_WR && hit_event && CFG_BE[LANE_ENABLE];
    endsequence
    sequence s_routing_write;
        CFG_WR && hit_routing;
    endsequence
    sequence s_routing_read;
        CFG_RD && hit_routing;
    endsequence

    a_enable_write: assert property (@(posedge CLK) disable iff (!RST_N)
        s_enable_write |=> enable == ($past(CFG_WDATA[15:8]) & EVENT_MASK))
        else $error("enable write not stored as masked");
    a_enable_holds: assert property (@(posedge CLK) disable iff (!RST_N)
        !(CFG_WR && hit_event && CFG_BE[LANE_ENABLE]) |=> $stable(enable))
        else $error("enable changed without write");
    a_out_write: assert property (@(posedge CLK) disable iff (!RST_N)
        s_out_write |=> out_drive == ($past(CFG_WDATA[31:24]) & GPIO_MASK))
        else $error("output write not stored as masked");
    a_out_holds: assert property (@(posedge CLK) disable iff (!RST_N)
        !(CFG_WR && hit_event && CFG_BE[LANE_OUTPUT]) |=> $stable(out_drive))
        else $error("output drive changed without write");
    a_route_write: assert property (@(posedge CLK) disable iff (!RST_N)
        s_routing_write ##0 (CFG_BE == 4'hF && !ROM_LOAD)
        |=> routing == ($past(CFG_WDATA) & ROUTING_MASK))
        else $error("routing write not stored as masked");
    a_route_holds: assert property (@(posedge CLK) disable iff (!RST_N)
        !(CFG_WR && hit_routing) && !ROM_LOAD |=> $stable(routing))
        else $error("routing changed without write or load");
    a_route_output: assert property (@(posedge CLK) disable iff (!RST_N)
        RST_N |=> MULTIPURPOSE_ROUTING == $past(routing[27:0]))
        else $error("routing terminals do not follow register");

    // ------------------------------------------------------------
    // Assertions: flags, inputs and event output
    // ------------------------------------------------------------
    // Look-back checks start only once reset has been sampled high
    a_vpp_flag: assert property (@(posedge CLK) disable iff (!RST_N)
        HIGH_VPP_EVENT |=> status[BIT_VPP])
        else $error("high vpp flag lost");
    a_status_clear: assert property (@(posedge CLK) disable iff (!RST_N)
        s_status_write ##0 (CFG_WDATA[BIT_POWER] && !POWER_CHANGE_EVENT)
        |=> !status[BIT_POWER])
        else $error("power flag not cleared by write");
    a_status_rsvd: assert property (@(posedge CLK) disable iff (!RST_N)
        RST_N |=> !status[BIT_RSVD])
        else $error("reserved status bit set");
    a_low_input_flag: assert property (@(posedge CLK) disable iff (!RST_N)
        RST_N |=> (status[2:0] | $past(input_level[2:0])) == 3'h7)
        else $error("low input did not set its flag");
    a_change_flag: assert property (@(posedge CLK) disable iff (!RST_N)
        RST_N |=> (status[4:3] | ~($past(input_level[4:3]) ^ $past(input_prev[4:3])))
                  == 2'h3)
        else $error("input change did not set its flag");
    a_input_sync: assert property (@(posedge CLK) disable iff (!RST_N)
        RST_N |=> input_level == $past(INPUT_TERMINAL, 2))
        else $error("input level skipped a synchroniser stage");
    a_event_level: assert property (@(posedge CLK) disable iff (!RST_N)
        RST_N |=> GENERAL_EVENT_OUTPUT_N == !$past(|(status & enable)))
        else $error("event output differs from enabled flags");

    // ------------------------------------------------------------
    // Assertions: read data
    // ------------------------------------------------------------
    a_enable_read: assert property (@(posedge CLK) disable iff (!RST_N)
        s_event_read |=> CFG_RDATA[15:8] == $past(enable))
        else $error("enable read differs from register");
    a_out_read: assert property (@(posedge CLK) disable iff (!RST_N)
        s_event_read |=> CFG_RDATA[28:24] == $past(out_drive[4:0]))
        else $error("output read differs from register");
    a_route_read: assert property (@(posedge CLK) disable iff (!RST_N)
        s_routing_read |=> CFG_RDATA[27:0] == $past(routing[27:0]))
        else $error("routing read differs from register");
endmodule : gpegr_top

// *** tb/gpegr_board.sv ***
/*
 Board-side model of the input and output terminals.
 Assumes the bench names the wanted input levels; outputs are only observed.
*/
`timescale 1ns/1ns
module gpegr_board (
    // Wanted levels and observed outputs
    input  wire logic [4:0] level,
    output logic      [4:0] seen,
    // Terminals
    output logic      [4:0] INPUT_TERMINAL,
    input  wire logic [4:0] OUTPUT_TERMINAL
);
    initial INPUT_TERMINAL = 5'h1F;
    // Pins move off the clock edge, as a real asynchronous source would
    always @(level) INPUT_TERMINAL <= #3 level;
    assign seen = OUTPUT_TERMINAL;
endmodule : gpegr_board

// *** tb/test_gp_event_gpio_regs.sv ***
/*
 Self-checking bench for the event, input, output and routing registers.
 Assumes the register set of gpegr_top and the board model gpegr_board.
*/
`timescale 1ns/1ns
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_fail++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module test_gp_event_gpio_regs;
    import gpegr_pkg::*;
    logic        CLK = 0, RST_N = 0, CFG_WR = 0, CFG_RD = 0, ROM_LOAD = 0;
    logic        POWER_CHANGE_EVENT = 0, HIGH_VPP_EVENT = 0, GEO_N;
    logic [7:0]  CFG_ADDR = 8'h00;
    logic [3:0]  CFG_BE = 4'h0;
    logic [31:0] CFG_WDATA = 32'h0, ROM_ROUTING = 32'h0, CFG_RDATA, d;
    logic [4:0]  level = 5'h1F, IN_T, OUT_T, seen;
    logic [27:0] ROUTE;
    int          n_fail = 0, n_tests = 0;
    always #10 CLK = ~CLK;
    gpegr_board board_u (.level(level), .seen(seen), .INPUT_TERMINAL(IN_T),
        .OUTPUT_TERMINAL(OUT_T));
    gpegr_top dut_u (.CLK(CLK), .RST_N(RST_N), .CFG_ADDR(CFG_ADDR), .CFG_BE(CFG_BE),
        .CFG_WR(CFG_WR), .CFG_RD(CFG_RD), .CFG_WDATA(CFG_WDATA), .CFG_RDATA(CFG_RDATA),
        .POWER_CHANGE_EVENT(POWER_CHANGE_EVENT), .HIGH_VPP_EVENT(HIGH_VPP_EVENT),
        .ROM_LOAD(ROM_LOAD), .ROM_ROUTING(ROM_ROUTING), .INPUT_TERMINAL(IN_T),
        .OUTPUT_TERMINAL(OUT_T), .GENERAL_EVENT_OUTPUT_N(GEO_N),
        .MULTIPURPOSE_ROUTING(ROUTE));
    // ------------------------------------------------------------
    // Bus cycles
    // ------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] v);
        @(posedge CLK);
        CFG_ADDR <= a;
        CFG_BE <= be;
        CFG_WDATA <= v;
        CFG_WR <= 1'b1;
        @(posedge CLK);
        CFG_WR <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge CLK);
        CFG_ADDR <= a;
        CFG_RD <= 1'b1;
        @(posedge CLK);
        CFG_RD <= 1'b0;
        #1 d = CFG_RDATA;
    endtask : rd
    task automatic wait_n(input int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask : wait_n
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        rd(OFS_STATUS);
        `CHK(d[31:8], {BYTE_RESET, 8'h1F, BYTE_RESET})
        `CHK(d[7:0], BYTE_RESET)
        `CHK(seen, 5'h00)
        rd(OFS_ROUTING);
        `CHK(d, ROUTING_RESET)
    endtask : t_reset
    task automatic t_masks;
        wr(OFS_STATUS, 4'hE, 32'hFFFFFFFF);
        rd(OFS_STATUS);
        `CHK(d[31:8], 24'h1F1FDF)
        `CHK(seen, 5'h1F)
        wr(OFS_STATUS, 4'h8, 32'h0A000000);
        wait_n(2);
        `CHK(seen, 5'h0A)
        rd(8'h40);
        `CHK(d, 32'h0)
    endtask : t_masks
    task automatic t_inputs;
        @(posedge CLK) level <= 5'h0A;
        wait_n(4);
        rd(OFS_INPUT);
        `CHK(d[23:16], 8'h0A)
        @(posedge CLK) level <= 5'h1F;
        wait_n(4);
    endtask : t_inputs
    task automatic t_event(input int b, input int masked);
        wr(OFS_STATUS, 4'h1, 32'hFF);
        wr(OFS_ENABLE, 4'h2, {16'h0, (masked ? EVENT_MASK & ~(8'h01 << b) : 8'h01 << b), 8'h0});
        @(posedge CLK);
        if (b == BIT_POWER) POWER_CHANGE_EVENT <= 1'b1;
        else if (b == BIT_VPP) HIGH_VPP_EVENT <= 1'b1;
        else level <= 5'h1F ^ (5'h01 << b);
        @(posedge CLK);
        POWER_CHANGE_EVENT <= 1'b0;
        HIGH_VPP_EVENT <= 1'b0;
        wait_n(4);
        `CHK(GEO_N, masked ? 1'b1 : 1'b0)
        rd(OFS_STATUS);
        `CHK(d[b], 1'b1)
        @(posedge CLK) level <= 5'h1F;
        wait_n(4);
        wr(OFS_STATUS, 4'h1, 32'hFF);
        wait_n(3);
        `CHK(GEO_N, 1'b1)
        rd(OFS_STATUS);
        `CHK(d[7:0], 8'h00)
    endtask : t_event
    task automatic t_routing;
        wr(OFS_ROUTING, 4'hF, 32'hFFFFFFFF);
        rd(OFS_ROUTING);
        `CHK(d, ROUTING_MASK)
        @(posedge CLK);
        ROM_ROUTING <= 32'hA5A5A5A5;
        ROM_LOAD <= 1'b1;
        @(posedge CLK) ROM_LOAD <= 1'b0;
        rd(OFS_ROUTING);
        `CHK(d, 32'h05A5A5A5)
        `CHK(ROUTE, 28'h5A5A5A5)
    endtask : t_routing
    // ------------------------------------------------------------
    // Sequence, watchdog and verdict
    // ------------------------------------------------------------
    task automatic tally_and_finish;
        if (n_fail == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (5) @(posedge CLK);
        RST_N <= 1'b1;
        t_reset();
        t_masks();
        t_inputs();
        for (int m = 0; m < 2; m++) begin
            t_event(7, m); t_event(6, m); t_event(4, m); t_event(3, m);
            t_event(2, m); t_event(1, m); t_event(0, m);
        end
        t_routing();
        @(posedge CLK) RST_N <= 1'b0;
        repeat (5) @(posedge CLK);
        RST_N <= 1'b1;
        t_reset();
        tally_and_finish();
    end
    initial begin
        repeat (5000) @(posedge CLK);
        n_fail++;
        tally_and_finish();
    end
endmodule : test_gp_event_gpio_regs
